// ===== core/adcsq_pkg.sv
// Shared constants for the sample sequencer control block
package adcsq_pkg;
	localparam int NUM_SEQ = 4;
	localparam int RES_W = 10;
	localparam int MAX_STEPS = 8;
	localparam int STEP_IDX_W = 3;
	localparam int PTR_W = 4;
	// Steps and queue depth per sequencer, index 0 to 3
	localparam logic [3:0] SEQ_DEPTH [NUM_SEQ] = '{4'h8, 4'h4, 4'h4, 4'h1};

	// Register byte offsets
	localparam logic [11:0] OFS_ACTIVE = 12'h000;
	localparam logic [11:0] OFS_RAW_IRQ = 12'h004;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFS_MIS_CLR = 12'h00c;
	localparam logic [11:0] OFS_OVF = 12'h010;
	localparam logic [11:0] OFS_TRIG_SEL = 12'h014;
	localparam logic [11:0] OFS_UNF = 12'h018;
	localparam logic [11:0] OFS_PRIO = 12'h020;
	localparam logic [11:0] OFS_SW_INIT = 12'h028;
	localparam logic [11:0] OFS_AVG = 12'h030;
	localparam logic [11:0] OFS_SEQ_BASE = 12'h040;
	localparam logic [11:0] OFS_SEQ_STRIDE = 12'h020;
	localparam logic [4:0] OFS_IN_SEL = 5'h00;
	localparam logic [4:0] OFS_STEP_CTL = 5'h04;
	localparam logic [4:0] OFS_RESULT = 5'h08;
	localparam logic [4:0] OFS_QSTAT = 5'h0c;

	// Step-control nibble fields
	localparam int CTL_DIFF = 0;
	localparam int CTL_END = 1;
	localparam int CTL_IE = 2;
	localparam int CTL_TEMP = 3;

	// Trigger select codes
	localparam logic [3:0] TRIG_SW = 4'h0;
	localparam logic [3:0] TRIG_TIMER = 4'h5;
	localparam logic [3:0] TRIG_PWM = 4'h6;
	localparam logic [3:0] TRIG_GPIO = 4'h4;
	localparam logic [3:0] TRIG_ALWAYS = 4'hf;

	// Reset values
	localparam logic [7:0] PRIO_RESET = 8'he4;
	localparam logic [2:0] AVG_RESET = 3'h0;

	// Converter clock: 100 MHz / 6 = 16.667 MHz
	localparam int CLK_MHZ = 100;
	localparam real CONV_CLK_MHZ = 16.667;
	localparam int CONV_DIV = int'(CLK_MHZ / CONV_CLK_MHZ + 0.5);
	// 500 ksps at the converter clock: one sample per 34 converter ticks
	localparam real SAMPLE_RATE_KSPS = 500.0;
	localparam int SAMPLE_TICKS = int'(CONV_CLK_MHZ * 1000.0 / SAMPLE_RATE_KSPS + 0.999);
	localparam int TICK_W = 6;

	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_REQ = 2'b01,
		ADCSQ_WAIT = 2'b10,
		ADCSQ_STORE = 2'b11
	} adcsq_state_e;
endpackage

// ===== core/adcsq_clkdiv.sv
// Converter clock enable divider
`timescale 1ns/1ps
module adcsq_clkdiv import adcsq_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	output logic tick
);
	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} adcsq_div_s;
	adcsq_div_s q, next_q;

	always_comb begin
		next_q = q;
		next_q.tick = 1'b0;
		if (q.cnt == 4'(CONV_DIV - 1)) begin
			next_q.cnt = 4'h0;
			next_q.tick = 1'b1;
		end else begin
			next_q.cnt = q.cnt + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick = q.tick;

	property p_tick_period;
		@(posedge clock) disable iff (!rst_b)
		tick |=> !tick [*5] ##1 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("converter tick period wrong");
endmodule

// ===== core/adcsq_queue.sv
// Circular result queue for one sequencer
`timescale 1ns/1ps
module adcsq_queue import adcsq_pkg::*; #(
	parameter logic [3:0] DEPTH = 4'h8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [RES_W-1:0] push_data,
	input wire logic pop,
	output logic [RES_W-1:0] head_data,
	output logic full,
	output logic empty,
	output logic [PTR_W-1:0] head_ptr,
	output logic [PTR_W-1:0] tail_ptr,
	output logic overflow,
	output logic underflow
);
	typedef struct packed {
		logic [2:0] wr;
		logic [2:0] rd;
		logic [3:0] count;
		logic [MAX_STEPS-1:0][RES_W-1:0] mem;
	} adcsq_q_s;
	adcsq_q_s q, next_q;
	logic [2:0] last;

	assign last = 3'(DEPTH - 4'h1);

	always_comb begin
		next_q = q;
		// Full queue drops the new result
		if (push && q.count != DEPTH) begin
			next_q.mem[q.wr] = push_data;
			next_q.wr = (q.wr == last) ? 3'h0 : q.wr + 3'h1;
		end
		if (pop && q.count != 4'h0) begin
			next_q.rd = (q.rd == last) ? 3'h0 : q.rd + 3'h1;
		end
		next_q.count = q.count + 4'(push && q.count != DEPTH) - 4'(pop && q.count != 4'h0);
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign head_data = q.mem[q.rd];
	assign full = (q.count == DEPTH);
	assign empty = (q.count == 4'h0);
	assign head_ptr = {1'b0, q.rd};
	assign tail_ptr = {1'b0, q.wr};
	assign overflow = push && full;
	assign underflow = pop && empty;

	property p_no_grow_full;
		@(posedge clock) disable iff (!rst_b)
		full && !pop |=> full && $stable(tail_ptr);
	endproperty
	a_no_grow_full: assert property (p_no_grow_full) else $error("full queue accepted data");

	property p_pop_moves_head;
		@(posedge clock) disable iff (!rst_b)
		pop && !empty && DEPTH != 4'h1 |=> head_ptr != $past(head_ptr);
	endproperty
	a_pop_moves_head: assert property (p_pop_moves_head) else $error("pop did not advance head");
endmodule

// ===== core/adcsq_top.sv
// Sample sequencer control: APB registers, arbitration, stepping, averaging
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Four sequencers, depths eight, four, four, one
// - Queue word carries ten-bit result low
// - Each step: input nibble plus control nibble
// - Control nibble: temp, irq, end, differential
// - Sequencer runs only while run bit set
// - Same input may repeat within sequence
// - Raw irq after steps with irq flag
// - Result read pops oldest circular entry
// - Status shows head, tail, full, empty
// - Per-sequencer overflow and underflow status registers
// - Control paced by 16.667 MHz converter enable
// - Irq line is raw gated by mask
// - Raw and masked status registers readable
// - Write one to masked status clears
// - Concurrent triggers served by priority value
// - Per-sequencer trigger source selection
// - Back-to-back conversions up to 500 ksps
// - Averaging of up to 64 conversions
// - Four external inputs plus temperature sensor
// - Differential pairs: zero is 0/1, one is 2/3
// - Software initiate bits start sequencers
// - Reset priority: zero highest, three lowest
// - Averaging off after reset
module adcsq_top import adcsq_pkg::*; (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TRIG_TIMER_IN,
	input wire logic TRIG_PWM_IN,
	input wire logic TRIG_GPIO_IN,
	output logic CONV_START,
	output logic [1:0] CONV_CHANNEL,
	output logic CONV_DIFF,
	output logic CONV_TEMP,
	input wire logic CONV_DONE,
	input wire logic [RES_W-1:0] CONV_RESULT,
	output logic [NUM_SEQ-1:0] SEQ_IRQ
);
	typedef struct packed {
		adcsq_state_e state;
		logic [NUM_SEQ-1:0] active;
		logic [NUM_SEQ-1:0] pending;
		logic [NUM_SEQ-1:0] raw_irq;
		logic [NUM_SEQ-1:0] mask;
		logic [NUM_SEQ-1:0] ovf;
		logic [NUM_SEQ-1:0] unf;
		logic [NUM_SEQ-1:0] trig_d;
		logic [NUM_SEQ-1:0][3:0] trig_sel;
		logic [NUM_SEQ-1:0][1:0] prio;
		logic [NUM_SEQ-1:0][31:0] in_sel;
		logic [NUM_SEQ-1:0][31:0] step_ctl;
		logic [2:0] avg;
		logic [1:0] cur;
		logic [STEP_IDX_W-1:0] step;
		logic [6:0] avg_cnt;
		logic [16:0] acc;
		logic [TICK_W-1:0] pace;
		logic conv_start;
		logic [1:0] conv_ch;
		logic conv_diff;
		logic conv_temp;
		logic [31:0] prdata;
		logic pready;
	} adcsq_top_s;
	adcsq_top_s q, next_q;

	logic tick;
	logic [NUM_SEQ-1:0] q_push, q_pop, q_full, q_empty, q_ovf, q_unf;
	logic [NUM_SEQ-1:0][RES_W-1:0] q_head;
	logic [NUM_SEQ-1:0][PTR_W-1:0] q_hptr, q_tptr;
	logic [RES_W-1:0] avg_result;
	logic [NUM_SEQ-1:0] trig_now;
	logic [NUM_SEQ-1:0] sw_start;
	logic wr_en, rd_en;
	logic [1:0] seq_idx;
	logic [4:0] seq_ofs;
	logic seq_space;
	logic [3:0] cur_in, cur_ctl;
	logic [6:0] avg_total;

	adcsq_clkdiv u_div (
		.clock(CLOCK),
		.rst_b(RST_B),
		.tick(tick)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_SEQ; g++) begin : g_seq
			adcsq_queue #(.DEPTH(SEQ_DEPTH[g])) u_queue (
				.clock(CLOCK),
				.rst_b(RST_B),
				.push(q_push[g]),
				.push_data(avg_result),
				.pop(q_pop[g]),
				.head_data(q_head[g]),
				.full(q_full[g]),
				.empty(q_empty[g]),
				.head_ptr(q_hptr[g]),
				.tail_ptr(q_tptr[g]),
				.overflow(q_ovf[g]),
				.underflow(q_unf[g])
			);
			always_comb begin
				case (q.trig_sel[g])
					TRIG_TIMER: trig_now[g] = TRIG_TIMER_IN;
					TRIG_PWM: trig_now[g] = TRIG_PWM_IN;
					TRIG_GPIO: trig_now[g] = TRIG_GPIO_IN;
					TRIG_ALWAYS: trig_now[g] = 1'b1;
					default: trig_now[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Access phase sampled once; pready then answers in the next cycle
	assign wr_en = PSEL && PENABLE && PWRITE && !q.pready;
	assign rd_en = PSEL && PENABLE && !PWRITE && !q.pready;
	assign seq_space = PADDR[11:6] != 6'h00 && PADDR[11:7] == 5'h00 || PADDR[11:6] == 6'h02;
	assign seq_idx = 2'(PADDR[6:5] - 2'h2);
	assign seq_ofs = PADDR[4:0];
	assign sw_start = (wr_en && PADDR == OFS_SW_INIT) ? PWDATA[NUM_SEQ-1:0] : '0;
	assign cur_in = q.in_sel[q.cur][q.step*4 +: 4];
	assign cur_ctl = q.step_ctl[q.cur][q.step*4 +: 4];
	assign avg_total = 7'h01 << q.avg;
	// Divide by the sample count, always a power of two
	assign avg_result = RES_W'(q.acc >> q.avg);

	always_comb begin
		next_q = q;
		next_q.conv_start = 1'b0;
		next_q.pready = 1'b0;
		q_push = '0;
		q_pop = '0;
		next_q.trig_d = trig_now;
		// Level triggers from the timer, pwm, gpio inputs act on the rising edge
		next_q.pending = q.pending | (trig_now & ~q.trig_d & q.active) | (sw_start & q.active);
		if (q.trig_sel != '0) begin
			for (int i = 0; i < NUM_SEQ; i++) begin
				if (q.trig_sel[i] == TRIG_ALWAYS && q.active[i]) begin
					next_q.pending[i] = 1'b1;
				end
			end
		end
		if (q.pace != '0 && tick) begin
			next_q.pace = q.pace - TICK_W'(1);
		end
		case (q.state)
			ADCSQ_IDLE: begin
				if (tick) begin
					for (int p = NUM_SEQ - 1; p >= 0; p--) begin
						for (int s = NUM_SEQ - 1; s >= 0; s--) begin
							if ((q.pending[s] & q.active[s]) && q.prio[s] == 2'(p)) begin
								next_q.cur = 2'(s);
							end
						end
					end
					if ((q.pending & q.active) != '0) begin
						next_q.state = ADCSQ_REQ;
						next_q.step = '0;
						next_q.avg_cnt = '0;
						next_q.acc = '0;
					end
				end
			end
			ADCSQ_REQ: begin
				if (tick && q.pace == '0) begin
					next_q.conv_start = 1'b1;
					next_q.pace = TICK_W'(SAMPLE_TICKS - 1);
					next_q.conv_diff = cur_ctl[CTL_DIFF];
					next_q.conv_temp = cur_ctl[CTL_TEMP];
					// Pair n uses inputs 2n and 2n+1
					next_q.conv_ch = cur_ctl[CTL_DIFF] ? {cur_in[0], 1'b0} : cur_in[1:0];
					next_q.state = ADCSQ_WAIT;
				end
			end
			ADCSQ_WAIT: begin
				if (CONV_DONE) begin
					next_q.acc = q.acc + 17'(CONV_RESULT);
					next_q.avg_cnt = q.avg_cnt + 7'h01;
					next_q.state = (q.avg_cnt + 7'h01 == avg_total) ? ADCSQ_STORE : ADCSQ_REQ;
				end
			end
			ADCSQ_STORE: begin
				q_push[q.cur] = 1'b1;
				next_q.avg_cnt = '0;
				next_q.acc = '0;
				if (cur_ctl[CTL_IE]) begin
					next_q.raw_irq[q.cur] = 1'b1;
				end
				if (cur_ctl[CTL_END] || 4'(q.step) == SEQ_DEPTH[q.cur] - 4'h1) begin
					next_q.pending[q.cur] = 1'b0;
					next_q.state = ADCSQ_IDLE;
				end else begin
					next_q.step = q.step + 3'h1;
					next_q.state = ADCSQ_REQ;
				end
			end
			default: next_q.state = ADCSQ_IDLE;
		endcase
		if (!q.active[q.cur] && q.state != ADCSQ_WAIT) begin
			next_q.state = ADCSQ_IDLE;
		end
		if (wr_en || rd_en) begin
			next_q.pready = 1'b1;
			next_q.prdata = '0;
		end
		if (wr_en) begin
			case (PADDR)
				OFS_ACTIVE: next_q.active = PWDATA[NUM_SEQ-1:0];
				OFS_IRQ_MASK: next_q.mask = PWDATA[NUM_SEQ-1:0];
				OFS_MIS_CLR: next_q.raw_irq = q.raw_irq & ~(PWDATA[NUM_SEQ-1:0] & q.mask);
				OFS_OVF: next_q.ovf = q.ovf & ~PWDATA[NUM_SEQ-1:0];
				OFS_UNF: next_q.unf = q.unf & ~PWDATA[NUM_SEQ-1:0];
				OFS_TRIG_SEL: next_q.trig_sel = PWDATA[15:0];
				OFS_PRIO: begin
					for (int i = 0; i < NUM_SEQ; i++) begin
						next_q.prio[i] = PWDATA[i*4 +: 2];
					end
				end
				OFS_AVG: next_q.avg = (PWDATA[2:0] > 3'h6) ? 3'h6 : PWDATA[2:0];
				default: begin
					if (seq_space && seq_ofs == OFS_IN_SEL) begin
						next_q.in_sel[seq_idx] = PWDATA;
					end else if (seq_space && seq_ofs == OFS_STEP_CTL) begin
						next_q.step_ctl[seq_idx] = PWDATA;
					end
				end
			endcase
		end
		if (rd_en) begin
			case (PADDR)
				OFS_ACTIVE: next_q.prdata = 32'(q.active);
				OFS_RAW_IRQ: next_q.prdata = 32'(q.raw_irq);
				OFS_IRQ_MASK: next_q.prdata = 32'(q.mask);
				OFS_MIS_CLR: next_q.prdata = 32'(q.raw_irq & q.mask);
				OFS_OVF: next_q.prdata = 32'(q.ovf);
				OFS_UNF: next_q.prdata = 32'(q.unf);
				OFS_TRIG_SEL: next_q.prdata = 32'(q.trig_sel);
				OFS_PRIO: begin
					for (int i = 0; i < NUM_SEQ; i++) begin
						next_q.prdata[i*4 +: 2] = q.prio[i];
					end
				end
				OFS_AVG: next_q.prdata = 32'(q.avg);
				default: begin
					if (seq_space && seq_ofs == OFS_IN_SEL) begin
						next_q.prdata = q.in_sel[seq_idx];
					end else if (seq_space && seq_ofs == OFS_STEP_CTL) begin
						next_q.prdata = q.step_ctl[seq_idx];
					end else if (seq_space && seq_ofs == OFS_RESULT) begin
						next_q.prdata = 32'(q_head[seq_idx]);
						q_pop[seq_idx] = 1'b1;
					end else if (seq_space && seq_ofs == OFS_QSTAT) begin
						next_q.prdata = {19'h0, q_full[seq_idx], 3'h0, q_empty[seq_idx],
							q_hptr[seq_idx], q_tptr[seq_idx]};
					end
				end
			endcase
		end
		// Hardware set wins over a same-cycle software clear
		next_q.ovf = next_q.ovf | q_ovf;
		next_q.unf = next_q.unf | q_unf;
		if (q.state == ADCSQ_STORE && cur_ctl[CTL_IE]) begin
			next_q.raw_irq[q.cur] = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			q <= '0;
			q.state <= ADCSQ_IDLE;
			q.avg <= AVG_RESET;
			for (int i = 0; i < NUM_SEQ; i++) begin
				q.prio[i] <= PRIO_RESET[i*2 +: 2];
			end
		end else begin
			q <= next_q;
		end
	end

	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = 1'b0;
	assign CONV_START = q.conv_start;
	assign CONV_CHANNEL = q.conv_ch;
	assign CONV_DIFF = q.conv_diff;
	assign CONV_TEMP = q.conv_temp;
	assign SEQ_IRQ = q.raw_irq & q.mask;

	property p_irq_gate;
		@(posedge CLOCK) disable iff (!RST_B)
		SEQ_IRQ == (q.raw_irq & q.mask);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not raw and mask");

	property p_idle_inactive;
		@(posedge CLOCK) disable iff (!RST_B)
		CONV_START |-> q.active[q.cur];
	endproperty
	a_idle_inactive: assert property (p_idle_inactive) else $error("conversion while disabled");

	property p_ie_sets_raw;
		@(posedge CLOCK) disable iff (!RST_B)
		q.state == ADCSQ_STORE && cur_ctl[CTL_IE] |=> q.raw_irq[$past(q.cur)];
	endproperty
	a_ie_sets_raw: assert property (p_ie_sets_raw) else $error("step irq not raised");

	property p_end_stops;
		@(posedge CLOCK) disable iff (!RST_B)
		q.state == ADCSQ_STORE && cur_ctl[CTL_END] |=> q.state == ADCSQ_IDLE;
	endproperty
	a_end_stops: assert property (p_end_stops) else $error("end flag ignored");

	property p_pace;
		@(posedge CLOCK) disable iff (!RST_B)
		CONV_START |=> !CONV_START [*8];
	endproperty
	a_pace: assert property (p_pace) else $error("conversions too close");

	property p_diff_even;
		@(posedge CLOCK) disable iff (!RST_B)
		CONV_START && CONV_DIFF |-> !CONV_CHANNEL[0];
	endproperty
	a_diff_even: assert property (p_diff_even) else $error("differential pair odd");

	property p_ready_next;
		@(posedge CLOCK) disable iff (!RST_B)
		PSEL && PENABLE && !PREADY |=> PREADY;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("apb answer late");

	property p_clear_mis;
		@(posedge CLOCK) disable iff (!RST_B)
		wr_en && PADDR == OFS_MIS_CLR && PWDATA[0] && q.mask[0] && q.state != ADCSQ_STORE
			|=> !q.raw_irq[0];
	endproperty
	a_clear_mis: assert property (p_clear_mis) else $error("irq clear failed");
endmodule

// ===== sim/adcsq_conv_model.sv
// Behavioural converter core: answers each start pulse after a set latency
`timescale 1ns/1ps
module adcsq_conv_model import adcsq_pkg::*; (
	input wire logic CLOCK,
	input wire logic CONV_START,
	input wire logic [1:0] CONV_CHANNEL,
	input wire logic CONV_DIFF,
	input wire logic CONV_TEMP,
	input wire logic [7:0] LATENCY,
	output logic CONV_DONE,
	output logic [RES_W-1:0] CONV_RESULT
);
	int cnt = -1;
	initial begin
		CONV_DONE = 1'b0;
		CONV_RESULT = '0;
	end
	always @(posedge CLOCK) begin
		CONV_DONE <= 1'b0;
		// Stale outside the done pulse, so the data keeps toggling
		CONV_RESULT <= ~CONV_RESULT;
		if (CONV_START) begin
			cnt <= LATENCY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			CONV_DONE <= 1'b1;
			CONV_RESULT <= {CONV_TEMP, CONV_DIFF, 6'h2a, CONV_CHANNEL};
			cnt <= -1;
		end
	end
endmodule

// ===== sim/testbench.sv
// Register-level bench for the sample sequencer control block
`timescale 1ns/1ps
module testbench import adcsq_pkg::*;;
	logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, start, diff, temp, done;
	logic [2:0] trig = 3'h0;
	logic [1:0] chan;
	logic [9:0] res;
	logic [3:0] irq;
	logic [7:0] lat = 8'h03;
	logic [1:0] chq[$];
	logic [3:0] codes [3];
	int error_cnt = 0, num_checks = 0, n0;

	adcsq_top dut_u (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TRIG_TIMER_IN(trig[0]), .TRIG_PWM_IN(trig[1]),
		.TRIG_GPIO_IN(trig[2]), .CONV_START(start), .CONV_CHANNEL(chan), .CONV_DIFF(diff),
		.CONV_TEMP(temp), .CONV_DONE(done), .CONV_RESULT(res), .SEQ_IRQ(irq));
	adcsq_conv_model conv_u (.CLOCK(clock), .CONV_START(start), .CONV_CHANNEL(chan),
		.CONV_DIFF(diff), .CONV_TEMP(temp), .LATENCY(lat), .CONV_DONE(done),
		.CONV_RESULT(res));

	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (start === 1'b1) begin
			chq.push_back(chan);
		end
	end

	function automatic logic [31:0] ev(logic t, logic d, logic [1:0] c);
		return {22'h0, t, d, 6'h2a, c};
	endfunction
	function automatic logic [11:0] sq(int n, logic [4:0] o);
		return OFS_SEQ_BASE + OFS_SEQ_STRIDE * 12'(n) + 12'(o);
	endfunction

	task automatic stop_test();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask
	// Polls a register field; a bound keeps a stuck sequencer from hanging the run
	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd & m) !== v && n < 500);
		if ((rd & m) !== v) begin
			error_cnt++;
			stop_test();
		end
	endtask

	initial begin
		codes = '{TRIG_TIMER, TRIG_PWM, TRIG_GPIO};
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rc("active", OFS_ACTIVE, 32'h0);
		rc("prio", OFS_PRIO, 32'h3210);
		rc("avg", OFS_AVG, 32'h0);
		rc("trig", OFS_TRIG_SEL, 32'h0);
		rc("unmapped", 12'h3fc, 32'h0);
		rc("qstat0", sq(0, OFS_QSTAT), 32'h100);
		chk("slverr", 32'h0, {31'h0, pslverr});
		$display("Test reset done");

		wr(sq(0, OFS_IN_SEL), 32'h22230111);
		wr(sq(0, OFS_STEP_CTL), 32'h00068014);
		wr(OFS_ACTIVE, 32'h1);
		wr(OFS_SW_INIT, 32'h1);
		poll(sq(0, OFS_QSTAT), 32'h11ff, 32'h05);
		chk("step chan", 32'h1, {30'h0, chq[0]});
		rc("in_sel0", sq(0, OFS_IN_SEL), 32'h22230111);
		rc("res0", sq(0, OFS_RESULT), ev(0, 0, 1));
		rc("res1", sq(0, OFS_RESULT), ev(0, 1, 2));
		rc("res2", sq(0, OFS_RESULT), ev(0, 0, 1));
		rc("res3", sq(0, OFS_RESULT), ev(1, 0, 0));
		rc("res4", sq(0, OFS_RESULT), ev(0, 0, 3));
		rc("qstat0", sq(0, OFS_QSTAT), 32'h155);
		chk("starts", 32'd5, chq.size());
		rc("raw", OFS_RAW_IRQ, 32'h1);
		chk("irq masked", 32'h0, {28'h0, irq});
		wr(OFS_IRQ_MASK, 32'h1);
		rc("mis", OFS_MIS_CLR, 32'h1);
		chk("irq line", 32'h1, {28'h0, irq});
		wr(OFS_MIS_CLR, 32'h1);
		rc("raw clr", OFS_RAW_IRQ, 32'h0);
		chk("irq off", 32'h0, {28'h0, irq});
		apb(1'b0, sq(0, OFS_RESULT), 32'h0);
		rc("unf", OFS_UNF, 32'h1);
		wr(OFS_UNF, 32'h1);
		rc("unf clr", OFS_UNF, 32'h0);
		$display("Test sequence done");

		wr(OFS_ACTIVE, 32'h0);
		wr(OFS_SW_INIT, 32'h1);
		repeat (300) @(posedge clock);
		chk("idle starts", 32'd5, chq.size());
		$display("Test disabled done");

		lat <= 8'd40;
		wr(sq(3, OFS_IN_SEL), 32'h2);
		wr(sq(3, OFS_STEP_CTL), 32'h2);
		wr(OFS_ACTIVE, 32'h8);
		wr(OFS_SW_INIT, 32'h8);
		poll(sq(3, OFS_QSTAT), 32'h1000, 32'h1000);
		// A different input for the dropped result shows which entry was kept
		wr(OFS_ACTIVE, 32'h0);
		wr(sq(3, OFS_IN_SEL), 32'h3);
		wr(OFS_ACTIVE, 32'h8);
		wr(OFS_SW_INIT, 32'h8);
		poll(OFS_OVF, 32'h8, 32'h8);
		rc("ovf keep", sq(3, OFS_RESULT), ev(0, 0, 2));
		rc("qstat3", sq(3, OFS_QSTAT), 32'h100);
		wr(OFS_OVF, 32'h8);
		rc("ovf clr", OFS_OVF, 32'h0);
		$display("Test overflow done");

		lat <= 8'h03;
		wr(OFS_AVG, 32'h2);
		n0 = chq.size();
		wr(OFS_SW_INIT, 32'h8);
		poll(sq(3, OFS_QSTAT), 32'h1000, 32'h1000);
		chk("avg starts", 32'd4, chq.size() - n0);
		rc("avg res", sq(3, OFS_RESULT), ev(0, 0, 3));
		wr(OFS_AVG, 32'h0);
		$display("Test averaging done");

		wr(sq(1, OFS_IN_SEL), 32'h1);
		wr(sq(1, OFS_STEP_CTL), 32'h2);
		wr(sq(2, OFS_IN_SEL), 32'h3);
		wr(sq(2, OFS_STEP_CTL), 32'h2);
		wr(OFS_PRIO, 32'h3012);
		wr(OFS_ACTIVE, 32'h6);
		chq.delete();
		wr(OFS_SW_INIT, 32'h6);
		poll(sq(1, OFS_QSTAT), 32'h100, 32'h0);
		poll(sq(2, OFS_QSTAT), 32'h100, 32'h0);
		chk("first served", 32'h3, {30'h0, chq[0]});
		chk("second served", 32'h1, {30'h0, chq[1]});
		rc("res s2", sq(2, OFS_RESULT), ev(0, 0, 3));
		rc("res s1", sq(1, OFS_RESULT), ev(0, 0, 1));
		$display("Test priority done");

		for (int k = 0; k < 3; k++) begin
			wr(OFS_TRIG_SEL, {24'h0, codes[k], 4'h0});
			@(posedge clock);
			trig[k] <= 1'b1;
			repeat (3) @(posedge clock);
			trig <= 3'h0;
			poll(sq(1, OFS_QSTAT), 32'h100, 32'h0);
			rc("trig res", sq(1, OFS_RESULT), ev(0, 0, 1));
		end
		wr(OFS_TRIG_SEL, 32'hf0);
		poll(sq(1, OFS_QSTAT), 32'h1000, 32'h1000);
		wr(OFS_TRIG_SEL, 32'h0);
		rc("always res", sq(1, OFS_RESULT), ev(0, 0, 1));
		$display("Test triggers done");
		stop_test();
	end
endmodule
